/* File: rtl/pbsp_ecc_lane.sv */
// Single-error-correcting code for one nine-bit byte lane.
// Assumes the caller registers both sides; this block is purely combinational.
`timescale 1ns/100ps
`default_nettype none
module pbsp_ecc_lane (
	input  wire logic [8:0] enc_data_i,
	output logic      [3:0] enc_chk_o,
	input  wire logic [8:0] dec_data_i,
	input  wire logic [3:0] dec_chk_i,
	output logic      [8:0] dec_fix_o
);
	logic [3:0] syn;

	always_comb begin
		enc_chk_o = 4'h0;
		syn       = dec_chk_i;
		for (int i = 0; i < 9; i++) begin
			for (int k = 0; k < 4; k++) begin
				if (pbsp_pkg::HAM_POS[4*i+k]) begin
					enc_chk_o[k] = enc_chk_o[k] ^ enc_data_i[i];
					syn[k]       = syn[k] ^ dec_data_i[i];
				end
			end
		end
		dec_fix_o = dec_data_i;
		// A check bit error gives a syndrome that matches no data bit
		for (int i = 0; i < 9; i++) begin
			if (syn == pbsp_pkg::HAM_POS[4*i +: 4]) begin
				dec_fix_o[i] = ~dec_data_i[i];
			end
		end
	end
endmodule
`default_nettype wire

/* File: rtl/pbsp_pkg.sv */
// Shared widths, codes and reset values for the burst memory port.
// Assumes a single 25 MHz clock domain and nothing else around it.
package pbsp_pkg;
	localparam int ADDR_W    = 20;
	localparam int HI_W      = 18;
	localparam int BURST_W   = 2;
	localparam int LANES     = 4;
	localparam int LANE_W    = 9;
	localparam int CHK_W     = 4;
	localparam int CELL_W    = 13;
	localparam int DATA_W    = 36;
	localparam int DEPTH     = 1048576;
	localparam int READ_CYCLES = 3;

	// Code word positions of the nine lane data bits
	localparam logic [35:0] HAM_POS = {4'hD, 4'hC, 4'hB, 4'hA, 4'h9, 4'h7, 4'h6, 4'h5, 4'h3};

	localparam logic [HI_W-1:0]    HI_RST    = 18'h00000;
	localparam logic [BURST_W-1:0] BURST_RST = 2'h0;
	localparam logic [LANES-1:0]   LANES_ALL = 4'hF;
	localparam logic [LANES-1:0]   LANES_NONE = 4'h0;

	typedef enum logic [1:0] {
		ST_DESEL = 2'b01,
		ST_SEL   = 2'b10
	} pbsp_state_t;
endpackage

/* File: rtl/pbsp_port.sv */
// Synchronous host port of a pipelined burst memory with its array.
// Assumes all synchronous inputs meet setup to mclk_i; the data pins are
// resolved outside from dq_o and dq_oe_o.
`timescale 1ns/100ps
`default_nettype none
module pbsp_port (
	input  wire logic        mclk_i,
	input  wire logic        rst_n_i,
	input  wire logic [17:0] addr_hi_i,
	input  wire logic        burst_base_bit0_i,
	input  wire logic        burst_base_bit1_i,
	input  wire logic        processor_address_strobe_n_i,
	input  wire logic        controller_address_strobe_n_i,
	input  wire logic        burst_step_n_i,
	input  wire logic        write_all_bytes_n_i,
	input  wire logic        byte_write_qualifier_n_i,
	input  wire logic [3:0]  byte_lane_select_n_i,
	input  wire logic        pipeline_chip_select_n_i,
	input  wire logic        depth_select_high_i,
	input  wire logic        depth_select_low_n_i,
	input  wire logic        output_enable_n_i,
	input  wire logic        sleep_request_i,
	input  wire logic        linear_order_i,
	input  wire logic [35:0] dq_i,
	output logic      [35:0] dq_o,
	output logic      [35:0] dq_oe_o
);
	// ****************************************
	// Strobe decode
	// ****************************************
	logic chips_on;
	logic psp_take;
	logic strobe;
	logic write_req;
	logic write_now;

	pbsp_pkg::pbsp_state_t state_reg;
	pbsp_pkg::pbsp_state_t state_next;
	logic [17:0] hi_reg;
	logic [17:0] hi_next;
	logic [1:0]  base_reg;
	logic [1:0]  base_next;
	logic [1:0]  cnt_reg;
	logic [1:0]  cnt_next;
	logic [1:0]  cur_low;
	logic [19:0] cur_addr;

	assign chips_on = ~pipeline_chip_select_n_i & depth_select_high_i
		& ~depth_select_low_n_i;
	assign psp_take = ~processor_address_strobe_n_i & ~pipeline_chip_select_n_i;
	// Strobes are ORed, neither has priority; both paths load identically here
	assign strobe = psp_take | ~controller_address_strobe_n_i;
	assign write_req = ~write_all_bytes_n_i
		| (~byte_write_qualifier_n_i & ~(&byte_lane_select_n_i));
	// Writes are taken in cycles after the address load only
	assign write_now = (state_reg == pbsp_pkg::ST_SEL) & ~strobe & ~sleep_request_i & write_req;

	// ****************************************
	// Address and burst counter
	// ****************************************
	always_comb begin
		state_next = state_reg;
		hi_next    = hi_reg;
		base_next  = base_reg;
		cnt_next   = cnt_reg;
		if (sleep_request_i) begin
			state_next = pbsp_pkg::ST_DESEL;
		end else if (strobe) begin
			if (chips_on) begin
				state_next = pbsp_pkg::ST_SEL;
				hi_next    = addr_hi_i;
				base_next  = {burst_base_bit1_i, burst_base_bit0_i};
				cnt_next   = pbsp_pkg::BURST_RST;
			end else begin
				state_next = pbsp_pkg::ST_DESEL;
			end
		end else if (state_reg == pbsp_pkg::ST_SEL && !burst_step_n_i) begin
			// Two-bit wrap keeps the burst inside its group of four
			cnt_next = cnt_reg + 2'h1;
		end
		// Advance high leaves the counter untouched
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_reg <= pbsp_pkg::ST_DESEL;
			hi_reg    <= pbsp_pkg::HI_RST;
			base_reg  <= pbsp_pkg::BURST_RST;
			cnt_reg   <= pbsp_pkg::BURST_RST;
		end else begin
			state_reg <= state_next;
			hi_reg    <= hi_next;
			base_reg  <= base_next;
			cnt_reg   <= cnt_next;
		end
	end

	assign cur_low  = linear_order_i ? (base_reg + cnt_reg) : (base_reg ^ cnt_reg);
	assign cur_addr = {hi_reg, cur_low};

	// ****************************************
	// Write capture and self-timed commit
	// ****************************************
	logic        wr_v_reg;
	logic        wr_v_next;
	logic [19:0] wr_addr_reg;
	logic [19:0] wr_addr_next;
	logic [35:0] wr_data_reg;
	logic [35:0] wr_data_next;
	logic [3:0]  wr_bytes_reg;
	logic [3:0]  wr_bytes_next;
	logic [3:0][3:0] wr_chk;

	always_comb begin
		wr_v_next     = write_now;
		wr_addr_next  = wr_addr_reg;
		wr_data_next  = wr_data_reg;
		wr_bytes_next = pbsp_pkg::LANES_NONE;
		if (write_now) begin
			wr_addr_next = cur_addr;
			wr_data_next = dq_i;
			if (!write_all_bytes_n_i) begin
				wr_bytes_next = pbsp_pkg::LANES_ALL;
			end else begin
				wr_bytes_next = ~byte_lane_select_n_i;
			end
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_v_reg     <= 1'b0;
			wr_addr_reg  <= {pbsp_pkg::HI_RST, pbsp_pkg::BURST_RST};
			wr_data_reg  <= 36'h000000000;
			wr_bytes_reg <= pbsp_pkg::LANES_NONE;
		end else begin
			wr_v_reg     <= wr_v_next;
			wr_addr_reg  <= wr_addr_next;
			wr_data_reg  <= wr_data_next;
			wr_bytes_reg <= wr_bytes_next;
		end
	end

	// ****************************************
	// Array, read pipeline and correction
	// ****************************************
	// Cells are left unreset; a real array powers up unknown too
	logic [3:0][12:0] mem_q [0:pbsp_pkg::DEPTH-1];
	logic [3:0][12:0] rd_raw_reg;
	logic [3:0][12:0] rd_raw_next;
	logic             rd_v_reg;
	logic             rd_v_next;
	logic [35:0]      dout_reg;
	logic [35:0]      dout_next;
	logic             dout_valid_reg;
	logic             dout_valid_next;
	logic [3:0][8:0]  rd_fix;

	always_ff @(posedge mclk_i) begin
		for (int l = 0; l < pbsp_pkg::LANES; l++) begin
			if (wr_v_reg && wr_bytes_reg[l]) begin
				mem_q[wr_addr_reg][l] <= {wr_chk[l], wr_data_reg[9*l +: 9]};
			end
		end
	end

	always_comb begin
		// A deselect edge reads nothing, so the drive stops one cycle later
		rd_v_next   = (state_reg == pbsp_pkg::ST_SEL) & ~write_now & ~sleep_request_i
			& ~(strobe & ~chips_on);
		rd_raw_next = mem_q[cur_addr];
		// Bypass a commit landing on the same edge as this read
		for (int l = 0; l < pbsp_pkg::LANES; l++) begin
			if (wr_v_reg && wr_bytes_reg[l] && wr_addr_reg == cur_addr) begin
				rd_raw_next[l] = {wr_chk[l], wr_data_reg[9*l +: 9]};
			end
		end
		dout_valid_next = rd_v_reg;
		dout_next       = dout_reg;
		if (rd_v_reg) begin
			dout_next = rd_fix;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rd_v_reg       <= 1'b0;
			rd_raw_reg     <= '0;
			dout_valid_reg <= 1'b0;
			dout_reg       <= 36'h000000000;
		end else begin
			rd_v_reg       <= rd_v_next;
			rd_raw_reg     <= rd_raw_next;
			dout_valid_reg <= dout_valid_next;
			dout_reg       <= dout_next;
		end
	end

	genvar g;
	generate
		for (g = 0; g < pbsp_pkg::LANES; g++) begin : g_lane
			pbsp_ecc_lane u_ecc (
				.enc_data_i (wr_data_reg[9*g +: 9]),
				.enc_chk_o  (wr_chk[g]),
				.dec_data_i (rd_raw_reg[g][8:0]),
				.dec_chk_i  (rd_raw_reg[g][12:9]),
				.dec_fix_o  (rd_fix[g])
			);
		end
	endgenerate

	// ****************************************
	// Pin drive
	// ****************************************
	// No clock in this path, so enable and sleep cut the drive at once
	assign dq_o    = dout_reg;
	assign dq_oe_o = {36{dout_valid_reg & ~output_enable_n_i & ~sleep_request_i}};

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!rst_n_i);

	sequence s_load;
		strobe && chips_on && !sleep_request_i;
	endsequence
	sequence s_read_cycle;
		!write_now && !sleep_request_i;
	endsequence
	sequence s_step;
		state_reg == pbsp_pkg::ST_SEL && !strobe && !sleep_request_i && !burst_step_n_i;
	endsequence
	sequence s_deselect;
		strobe && !chips_on;
	endsequence

	AST_READ_LATENCY: assert property (s_load ##1 s_read_cycle |-> ##2 dout_valid_reg)
		else $error("first read word late or missing");
	AST_OUT_REG: assert property (rd_v_reg
		|=> dout_valid_reg && dout_reg == $past(rd_fix))
		else $error("read word not registered");
	AST_LOAD: assert property (s_load |=> state_reg == pbsp_pkg::ST_SEL
		&& cnt_reg == 2'h0 && hi_reg == $past(addr_hi_i)
		&& base_reg == $past({burst_base_bit1_i, burst_base_bit0_i}))
		else $error("address load wrong");
	AST_STEP: assert property (s_step |=> cnt_reg == $past(cnt_reg) + 2'h1)
		else $error("burst did not step");
	AST_HOLD: assert property (state_reg == pbsp_pkg::ST_SEL && !strobe
		&& burst_step_n_i |=> $stable(cnt_reg))
		else $error("burst moved without advance");
	AST_WRAP: assert property (s_step [*4] |=> cur_low == $past(cur_low, 4))
		else $error("burst did not wrap to start");
	AST_PSP_IGNORED: assert property (!processor_address_strobe_n_i
		&& pipeline_chip_select_n_i && controller_address_strobe_n_i && !sleep_request_i
		|=> $stable(state_reg) && $stable(hi_reg))
		else $error("processor strobe taken while deselected");
	AST_DESELECT: assert property (s_deselect
		|=> state_reg == pbsp_pkg::ST_DESEL && !rd_v_reg)
		else $error("deselect late");
	AST_DRIVE_STOP: assert property (s_deselect |-> ##2 !dout_valid_reg)
		else $error("read drive outlived deselect");
	AST_GLOBAL_WRITE: assert property (write_now && !write_all_bytes_n_i
		|=> wr_v_reg && wr_bytes_reg == pbsp_pkg::LANES_ALL)
		else $error("global write missed bytes");
	AST_BYTE_WRITE: assert property (write_now && write_all_bytes_n_i
		|=> wr_bytes_reg == ~$past(byte_lane_select_n_i))
		else $error("byte lanes wrong");
	AST_WRITE_TAKEN: assert property (write_now
		|=> wr_v_reg && wr_addr_reg == $past(cur_addr) && wr_data_reg == $past(dq_i))
		else $error("write not registered");
	AST_LOAD_NO_WRITE: assert property (strobe |=> !wr_v_reg)
		else $error("write taken on a load edge");
	AST_SLEEP: assert property (sleep_request_i
		|=> state_reg == pbsp_pkg::ST_DESEL && !rd_v_reg && !wr_v_reg)
		else $error("sleep did not deselect");
	AST_NO_DRIVE: assert property (output_enable_n_i || sleep_request_i
		|-> dq_oe_o == 36'h000000000)
		else $error("pins driven while disabled");
endmodule
`default_nettype wire

/* File: verification/pbsp_host_model.sv */
// Host side model: resolves the shared data wires of the port.
// Assumes the bench supplies write data and a drive enable.
`timescale 1ns/100ps
`default_nettype none
module pbsp_host_model (
	input  wire logic        mclk_i,
	input  wire logic        drive_en_i,
	input  wire logic [35:0] wdata_i,
	input  wire logic [35:0] dq_o,
	input  wire logic [35:0] dq_oe_o,
	output logic      [35:0] dq_i
);
	logic [35:0] last_reg = 36'h0_0000_0000;
	// Released wires flip each cycle, so stale data never passes
	always_comb begin
		if (drive_en_i) begin
			dq_i = wdata_i;
		end else if (dq_oe_o[0]) begin
			dq_i = dq_o;
		end else begin
			dq_i = ~last_reg;
		end
	end
	always @(posedge mclk_i) begin
		last_reg <= dq_i;
	end
endmodule
`default_nettype wire

/* File: verification/pbsp_port_tb.sv */
// Self-checking bench for the burst memory port.
// Assumes a host model resolves the data wires; inputs move at falling edges.
`timescale 1ns/100ps
`default_nettype none
module pbsp_port_tb;
	logic        mclk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic [1:0]  base = 2'h0;
	logic        p_stb_n = 1'b1;
	logic        c_stb_n = 1'b1;
	logic        step_n = 1'b1;
	logic        gw_n = 1'b1;
	logic        bwe_n = 1'b1;
	logic [3:0]  lane_n = 4'hF;
	logic        pcs_n = 1'b0;
	logic        dsh = 1'b1;
	logic        dsl_n = 1'b0;
	logic        oe_n = 1'b0;
	logic        sleep = 1'b0;
	logic        linear = 1'b1;
	logic        drive_en = 1'b0;
	logic [35:0] wdata = 36'h0_0000_0000;
	logic [35:0] dq_i;
	logic [35:0] dq_o;
	logic [35:0] dq_oe;
	logic [35:0] mem_exp [4];
	int          err_count = 0;
	int          total_checks = 0;
	int          cyc = 0;
	localparam logic [35:0] ONES = 36'hF_FFFF_FFFF;
	localparam logic [35:0] ZERO = 36'h0_0000_0000;

	pbsp_port uut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_hi_i(18'h2A5C3),
		.burst_base_bit0_i(base[0]), .burst_base_bit1_i(base[1]),
		.processor_address_strobe_n_i(p_stb_n), .controller_address_strobe_n_i(c_stb_n),
		.burst_step_n_i(step_n), .write_all_bytes_n_i(gw_n),
		.byte_write_qualifier_n_i(bwe_n), .byte_lane_select_n_i(lane_n),
		.pipeline_chip_select_n_i(pcs_n), .depth_select_high_i(dsh),
		.depth_select_low_n_i(dsl_n), .output_enable_n_i(oe_n),
		.sleep_request_i(sleep), .linear_order_i(linear), .dq_i(dq_i),
		.dq_o(dq_o), .dq_oe_o(dq_oe));
	pbsp_host_model host (.mclk_i(mclk_i), .drive_en_i(drive_en), .wdata_i(wdata),
		.dq_o(dq_o), .dq_oe_o(dq_oe), .dq_i(dq_i));

	always #20 mclk_i = ~mclk_i;

	task automatic end_sim();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Ceiling is over twenty-five times the expected run of about 72 cycles
	always @(posedge mclk_i) begin
		cyc++;
		if (cyc == 2000) begin
			err_count++;
			end_sim();
		end
	end

	task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH %s exp %h seen %h", what, exp, seen);
		end
	endtask

	function automatic logic [35:0] pat(input int i);
		return 36'h9_8765_4321 + 36'(i) * 36'h1_0101_0101;
	endfunction

	// Mode bit 0 = processor strobe, bit 1 = controller strobe
	task automatic load(input logic [1:0] b, input logic [1:0] mode);
		@(negedge mclk_i);
		base = b;
		p_stb_n = ~mode[0];
		c_stb_n = ~mode[1];
		@(negedge mclk_i);
		p_stb_n = 1'b1;
		c_stb_n = 1'b1;
	endtask

	task automatic wr(input logic [1:0] b, input logic [35:0] d, input logic [3:0] ln,
		input logic g);
		load(b, 2'h1);
		gw_n = ~g;
		bwe_n = g;
		lane_n = ln;
		wdata = d;
		drive_en = 1'b1;
		for (int l = 0; l < 4; l++) begin
			if (g || !ln[l]) begin
				mem_exp[b][9*l +: 9] = d[9*l +: 9];
			end
		end
		@(negedge mclk_i);
		gw_n = 1'b1;
		bwe_n = 1'b1;
		lane_n = 4'hF;
		drive_en = 1'b0;
	endtask

	task automatic rd(input logic [1:0] b, input logic [1:0] mode, input logic lin);
		logic [1:0] k;
		load(b, mode);
		// Order changes only after the load, so an old burst never sees it
		linear = lin;
		step_n = 1'b0;
		@(negedge mclk_i);
		for (int i = 0; i < 4; i++) begin
			k = 2'(i);
			@(negedge mclk_i);
			check("burst word", dq_o, mem_exp[lin ? b + k : b ^ k]);
			check("read drive", dq_oe, ONES);
		end
		step_n = 1'b1;
	endtask

	task automatic hold_step();
		load(2'h1, 2'h1);
		@(negedge mclk_i);
		step_n = 1'b0;
		@(negedge mclk_i);
		check("hold w0", dq_o, mem_exp[1]);
		@(negedge mclk_i);
		check("hold w1", dq_o, mem_exp[1]);
		@(negedge mclk_i);
		check("hold w2", dq_o, mem_exp[2]);
		step_n = 1'b1;
	endtask

	task automatic async_ctl();
		@(negedge mclk_i);
		oe_n = 1'b1;
		#1 check("oe off", dq_oe, ZERO);
		// Held across an edge so the clocked checks see it too
		@(negedge mclk_i);
		check("oe held off", dq_oe, ZERO);
		oe_n = 1'b0;
		#1 check("oe on", dq_oe, ONES);
		sleep = 1'b1;
		#1 check("sleep off", dq_oe, ZERO);
		sleep = 1'b0;
		#1 check("sleep on", dq_oe, ONES);
		sleep = 1'b1;
		@(negedge mclk_i);
		sleep = 1'b0;
		@(negedge mclk_i);
		check("sleep deselect", dq_oe, ZERO);
	endtask

	// Sleep left the port deselected, so it is selected again first
	task automatic desel();
		load(2'h1, 2'h2);
		@(negedge mclk_i);
		@(negedge mclk_i);
		check("reselect", dq_oe, ONES);
		check("reselect word", dq_o, mem_exp[1]);
		pcs_n = 1'b1;
		load(2'h1, 2'h1);
		@(negedge mclk_i);
		check("ignored strobe", dq_oe, ONES);
		pcs_n = 1'b0;
		dsl_n = 1'b1;
		load(2'h1, 2'h2);
		@(negedge mclk_i);
		check("deselect", dq_oe, ZERO);
		@(negedge mclk_i);
		check("stay off", dq_oe, ZERO);
		dsl_n = 1'b0;
		pcs_n = 1'b1;
		dsh = 1'b0;
		load(2'h1, 2'h2);
		@(negedge mclk_i);
		check("still off", dq_oe, ZERO);
		pcs_n = 1'b0;
		dsh = 1'b1;
	endtask

	initial begin
		repeat (2) @(posedge mclk_i);
		@(negedge mclk_i);
		rst_n_i = 1'b1;
		check("reset drive", dq_oe, ZERO);
		for (int i = 0; i < 4; i++) begin
			wr(2'(i), pat(i), 4'hA, 1'b1);
		end
		rd(2'h2, 2'h1, 1'b1);
		rd(2'h1, 2'h2, 1'b0);
		rd(2'h3, 2'h3, 1'b0);
		wr(2'h0, pat(9), 4'hE, 1'b0);
		wr(2'h3, pat(7), 4'h5, 1'b0);
		rd(2'h0, 2'h1, 1'b1);
		hold_step();
		async_ctl();
		desel();
		end_sim();
	end
endmodule
`default_nettype wire
